// ### src/fsi_pkg.sv
package fsi_pkg;

  // Selector codes on the access port.
  localparam logic [2:0] SEL_STATUS_ONE = 3'h0;
  localparam logic [2:0] SEL_STATUS_TWO = 3'h1;
  localparam logic [2:0] SEL_RX_INFO = 3'h2;
  localparam logic [2:0] SEL_HDLC_FLAG = 3'h3;
  localparam logic [2:0] SEL_SYNC_STATE = 3'h4;
  localparam logic [2:0] SEL_MASK_ONE = 3'h5;
  localparam logic [2:0] SEL_MASK_TWO = 3'h6;
  localparam logic [2:0] SEL_HDLC_MASK = 3'h7;

  // Index of each latched register and of each source byte.
  localparam logic [1:0] LAT_STATUS_ONE = 2'h0;
  localparam logic [1:0] LAT_STATUS_TWO = 2'h1;
  localparam logic [1:0] LAT_RX_INFO = 2'h2;
  localparam logic [1:0] LAT_HDLC_FLAG = 2'h3;
  localparam logic [2:0] SRC_SYNC_STATE = 3'h4;
  localparam int NUM_LATCHED = 4;
  localparam int NUM_SOURCES = 5;

  // Mask register indexes.
  localparam logic [1:0] MSK_ONE = 2'h0;
  localparam logic [1:0] MSK_TWO = 2'h1;
  localparam logic [1:0] MSK_HDLC = 2'h2;

  // Bit positions in status_reg_one.
  localparam int B_RX_SIG_ALL_ONES = 0;
  localparam int B_RX_DISTANT_MF_ALARM = 1;
  localparam int B_RX_SIG_ALL_ZEROS = 2;
  localparam int B_RX_SLIP_EVENT = 3;
  localparam int B_RX_UNFRAMED_ALL_ONES = 4;
  localparam int B_RX_REMOTE_ALARM = 5;
  localparam int B_RX_CARRIER_LOSS = 6;
  localparam int B_RX_SYNC_LOSS = 7;

  // Bit positions in status_reg_two.
  localparam int B_RX_MULTIFRAME_EVENT = 0;
  localparam int B_RX_ALIGN_FRAME_EVENT = 1;
  localparam int B_TX_MULTIFRAME_EVENT = 2;
  localparam int B_ONE_SECOND_TICK = 3;
  localparam int B_TX_ALIGN_FRAME_EVENT = 4;
  localparam int B_TX_CLOCK_LOSS = 5;
  localparam int B_RX_CRC_MULTIFRAME_EVENT = 6;
  localparam int B_TX_SLIP_EVENT = 7;

  typedef logic [7:0] fsi_byte_type;
  typedef fsi_byte_type [NUM_SOURCES-1:0] fsi_src_type;
  typedef fsi_byte_type [NUM_LATCHED-1:0] fsi_lat_type;

  // Level-type bits set whenever high; the others set on a rising edge.
  localparam fsi_lat_type LEVEL_MASK = {8'hff, 8'hff, 8'h00, 8'hf7};
  // Alarms in status_reg_one that interrupt on every change of state.
  localparam fsi_byte_type COS_MASK = 8'hf0;

  // One access on the control port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] sel;
    fsi_byte_type wdata;
  } fsi_acc_type;

  // Whole state of one framer's status logic.
  typedef struct packed {
    fsi_src_type s1;
    fsi_src_type s2;
    fsi_src_type prev;
    fsi_lat_type latch;
    fsi_lat_type copy;
    logic [NUM_LATCHED-1:0] armed;
    logic [NUM_LATCHED-1:0] rd_seen;
    fsi_byte_type cos;
    fsi_byte_type [2:0] mask;
    fsi_byte_type rdata;
    logic int_n;
  } fsi_state_type;

  localparam logic INT_IDLE = 1'b1;

endpackage

// ### src/fsi_top.sv
`timescale 1ns/100ps
module fsi_top (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire fsi_pkg::fsi_src_type FLAG_IN,
  input wire fsi_pkg::fsi_acc_type ACCESS,
  output logic [7:0] REG_RDATA,
  output logic INT_N
);

  // One instance serves one framer, so no state is shared between framers.
  fsi_pkg::fsi_state_type st_reg;
  fsi_pkg::fsi_state_type st_next;
  fsi_pkg::fsi_lat_type set_vec;
  fsi_pkg::fsi_byte_type cos_chg;
  logic is_latched;
  logic [1:0] idx;

  // Gathers the interrupt requests of a state; the info register is left out.
  function automatic fsi_pkg::fsi_byte_type pending_of(
    input fsi_pkg::fsi_state_type s
  );
    fsi_pkg::fsi_byte_type p;
    p = ((s.latch[fsi_pkg::LAT_STATUS_ONE] & ~fsi_pkg::COS_MASK) | s.cos)
        & s.mask[fsi_pkg::MSK_ONE];
    p = p | (s.latch[fsi_pkg::LAT_STATUS_TWO] & s.mask[fsi_pkg::MSK_TWO]);
    p = p | (s.latch[fsi_pkg::LAT_HDLC_FLAG] & s.mask[fsi_pkg::MSK_HDLC]);
    return p;
  endfunction

  assign is_latched = (ACCESS.sel < fsi_pkg::SEL_SYNC_STATE);
  assign idx = ACCESS.sel[1:0];

  // Works out the next state from the synchronised flags and the access.
  always_comb begin
    st_next = st_reg;
    st_next.s1 = FLAG_IN;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    // Level bits set while high, event bits on their rising edge.
    for (int i = 0; i < fsi_pkg::NUM_LATCHED; i++) begin
      set_vec[i] = (st_reg.s2[i] & fsi_pkg::LEVEL_MASK[i])
          | (st_reg.s2[i] & ~st_reg.prev[i] & ~fsi_pkg::LEVEL_MASK[i]);
      st_next.latch[i] = st_reg.latch[i] | set_vec[i];
    end
    cos_chg = (st_reg.s2[fsi_pkg::LAT_STATUS_ONE]
        ^ st_reg.prev[fsi_pkg::LAT_STATUS_ONE]) & fsi_pkg::COS_MASK;
    st_next.cos = st_reg.cos | cos_chg;
    if (ACCESS.wr && is_latched) begin
      if (st_reg.armed[idx] && st_reg.rd_seen[idx]) begin
        // Write-back clears only the ones written; a new set wins.
        st_next.latch[idx] = (st_reg.latch[idx] & ~ACCESS.wdata)
            | set_vec[idx];
        if (idx == fsi_pkg::LAT_STATUS_ONE) begin
          st_next.cos = (st_reg.cos & ~ACCESS.wdata) | cos_chg;
        end
        st_next.armed[idx] = 1'b0;
        st_next.rd_seen[idx] = 1'b0;
      end else begin
        // Mask write refreshes the selected bits of the readable copy.
        st_next.copy[idx] = (st_reg.latch[idx] & ACCESS.wdata)
            | (st_reg.copy[idx] & ~ACCESS.wdata);
        st_next.armed[idx] = 1'b1;
        st_next.rd_seen[idx] = 1'b0;
      end
    end else if (ACCESS.wr) begin
      case (ACCESS.sel)
        fsi_pkg::SEL_MASK_ONE: begin
          st_next.mask[fsi_pkg::MSK_ONE] = ACCESS.wdata;
        end
        fsi_pkg::SEL_MASK_TWO: begin
          st_next.mask[fsi_pkg::MSK_TWO] = ACCESS.wdata;
        end
        fsi_pkg::SEL_HDLC_MASK: begin
          st_next.mask[fsi_pkg::MSK_HDLC] = ACCESS.wdata;
        end
        default: begin
          st_next.rdata = st_reg.rdata;
        end
      endcase
    end
    // A read answers one cycle later from the copy, masks or live state.
    if (ACCESS.rd) begin
      case (ACCESS.sel)
        fsi_pkg::SEL_SYNC_STATE: begin
          st_next.rdata = st_reg.s2[fsi_pkg::SRC_SYNC_STATE];
        end
        fsi_pkg::SEL_MASK_ONE: begin
          st_next.rdata = st_reg.mask[fsi_pkg::MSK_ONE];
        end
        fsi_pkg::SEL_MASK_TWO: begin
          st_next.rdata = st_reg.mask[fsi_pkg::MSK_TWO];
        end
        fsi_pkg::SEL_HDLC_MASK: begin
          st_next.rdata = st_reg.mask[fsi_pkg::MSK_HDLC];
        end
        default: begin
          st_next.rdata = st_reg.copy[idx];
          if (st_reg.armed[idx] && !(ACCESS.wr && is_latched)) begin
            st_next.rd_seen[idx] = 1'b1;
          end
        end
      endcase
    end
    st_next.int_n = ~(|pending_of(st_next));
  end

  // Registers the whole state.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg <= fsi_pkg::fsi_state_type'(fsi_pkg::INT_IDLE);
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA = st_reg.rdata;
  assign INT_N = st_reg.int_n;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence mask_write_s;
    ACCESS.wr && is_latched && !(st_reg.armed[idx] && st_reg.rd_seen[idx]);
  endsequence

  sequence clear_write_s;
    ACCESS.wr && is_latched && st_reg.armed[idx] && st_reg.rd_seen[idx];
  endsequence

  // The interrupt pin always mirrors the gated requests of the state.
  irq_mirror_a: assert property (
    INT_N == ~(|pending_of(st_reg)))
    else $error("interrupt pin does not match pending requests");

  // Mask ones load the latest flags into the copy.
  copy_load_a: assert property (
    mask_write_s |=> ((st_reg.copy[$past(idx)] & $past(ACCESS.wdata))
        == ($past(st_reg.latch[idx]) & $past(ACCESS.wdata))))
    else $error("mask write did not refresh selected copy bits");

  // Mask zeros keep the copy as it was.
  copy_hold_a: assert property (
    mask_write_s |=> ((st_reg.copy[$past(idx)] & ~$past(ACCESS.wdata))
        == ($past(st_reg.copy[idx]) & ~$past(ACCESS.wdata))))
    else $error("mask write disturbed unselected copy bits");

  // Write-back clears the ones written unless they set again.
  clear_sel_a: assert property (
    clear_write_s |=> ((st_reg.latch[$past(idx)] & $past(ACCESS.wdata)
        & ~$past(set_vec[idx])) == 8'h00))
    else $error("write-back left a selected flag set");

  // Write-back keeps the bits written zero.
  clear_keep_a: assert property (
    clear_write_s |=> ((st_reg.latch[$past(idx)] & ~$past(ACCESS.wdata))
        == ($past(st_reg.latch[idx]) & ~$past(ACCESS.wdata))))
    else $error("write-back cleared an unselected flag");

  // A persisting level alarm is set in the next cycle.
  alarm_persist_a: assert property (
    (|(st_reg.s2[fsi_pkg::LAT_STATUS_ONE] & fsi_pkg::LEVEL_MASK[0]))
    |=> ((st_reg.latch[fsi_pkg::LAT_STATUS_ONE]
        & $past(st_reg.s2[fsi_pkg::LAT_STATUS_ONE])
        & fsi_pkg::LEVEL_MASK[0]) != 8'h00))
    else $error("persisting alarm flag not set");

  // A rising event edge sets its flag.
  event_set_a: assert property (
    (|(st_reg.s2[fsi_pkg::LAT_STATUS_TWO]
        & ~st_reg.prev[fsi_pkg::LAT_STATUS_TWO]))
    |=> ((st_reg.latch[fsi_pkg::LAT_STATUS_TWO]
        & $past(st_reg.s2[fsi_pkg::LAT_STATUS_TWO])) != 8'h00))
    else $error("event edge did not set its flag");

  // A set flag stays set while no write-back reaches it.
  flag_latched_a: assert property (
    !(ACCESS.wr && is_latched)
    |=> ((st_reg.latch & $past(st_reg.latch)) == $past(st_reg.latch)))
    else $error("latched flag dropped without write-back");

  // A sync state read returns the live synchroniser state.
  sync_live_a: assert property (
    (ACCESS.rd && ACCESS.sel == fsi_pkg::SEL_SYNC_STATE)
    |=> (REG_RDATA == $past(st_reg.s2[fsi_pkg::SRC_SYNC_STATE])))
    else $error("sync state read not live");

  // An unmasked alarm change pulls the interrupt low next cycle.
  alarm_change_a: assert property (
    (|(cos_chg & st_reg.mask[fsi_pkg::MSK_ONE])) |=> !INT_N)
    else $error("alarm change did not raise the interrupt");

  // A read of a latched register that arms the clear step.
  sequence arming_read_s;
    ACCESS.rd && is_latched && !ACCESS.wr && st_reg.armed[idx];
  endsequence

  // A write-back on the second status register.
  sequence event_clear_s;
    clear_write_s ##0 (idx == fsi_pkg::LAT_STATUS_TWO);
  endsequence

  // A write-back on the first status register.
  sequence alarm_clear_s;
    clear_write_s ##0 (idx == fsi_pkg::LAT_STATUS_ONE);
  endsequence

  // A read of a latched register answers from its readable copy.
  read_copy_a: assert property (
    (ACCESS.rd && is_latched)
    |=> (REG_RDATA == $past(st_reg.copy[idx])))
    else $error("latched read did not return the copy");

  // Read data stands until the next read.
  rdata_hold_a: assert property (
    !ACCESS.rd |=> $stable(REG_RDATA))
    else $error("read data changed without a read");

  // A read after the mask write completes the arming.
  read_arms_a: assert property (
    arming_read_s |=> st_reg.rd_seen[$past(idx)])
    else $error("armed read was not recorded");

  // Write-back clears chosen event flags that did not recur.
  event_clear_a: assert property (
    event_clear_s
    |=> ((st_reg.latch[fsi_pkg::LAT_STATUS_TWO] & $past(ACCESS.wdata)
        & ~$past(set_vec[fsi_pkg::LAT_STATUS_TWO])) == 8'h00))
    else $error("event flag survived its write-back");

  // An event flag only comes up when its event is seen.
  event_once_a: assert property (
    1'b1
    |=> ((st_reg.latch[fsi_pkg::LAT_STATUS_TWO]
        & ~$past(st_reg.latch[fsi_pkg::LAT_STATUS_TWO])
        & ~$past(set_vec[fsi_pkg::LAT_STATUS_TWO])) == 8'h00))
    else $error("event flag set without an event");

  // Write-back clears the chosen change-of-state requests.
  cos_clear_a: assert property (
    alarm_clear_s
    |=> ((st_reg.cos & $past(ACCESS.wdata) & ~$past(cos_chg)) == 8'h00))
    else $error("alarm change request survived its write-back");

  // A write to the sync state register changes no stored state.
  sync_ro_a: assert property (
    (ACCESS.wr && ACCESS.sel == fsi_pkg::SEL_SYNC_STATE)
    |=> (st_reg.copy == $past(st_reg.copy)
        && st_reg.mask == $past(st_reg.mask)))
    else $error("write to sync state register took effect");

  // The first mask register loads the byte written to it.
  mask_one_a: assert property (
    (ACCESS.wr && ACCESS.sel == fsi_pkg::SEL_MASK_ONE)
    |=> (st_reg.mask[fsi_pkg::MSK_ONE] == $past(ACCESS.wdata)))
    else $error("first mask register not loaded");

  // The second mask register loads the byte written to it.
  mask_two_a: assert property (
    (ACCESS.wr && ACCESS.sel == fsi_pkg::SEL_MASK_TWO)
    |=> (st_reg.mask[fsi_pkg::MSK_TWO] == $past(ACCESS.wdata)))
    else $error("second mask register not loaded");

  // The HDLC mask register loads the byte written to it.
  mask_hdlc_a: assert property (
    (ACCESS.wr && ACCESS.sel == fsi_pkg::SEL_HDLC_MASK)
    |=> (st_reg.mask[fsi_pkg::MSK_HDLC] == $past(ACCESS.wdata)))
    else $error("HDLC mask register not loaded");

  // With every mask clear, no flag can pull the pin low.
  all_masked_a: assert property (
    (st_reg.mask == '0 && !ACCESS.wr) |=> INT_N)
    else $error("interrupt asserted while all sources masked");

  // An unmasked event pulls the pin low in the next cycle.
  event_irq_a: assert property (
    ((|(set_vec[fsi_pkg::LAT_STATUS_TWO] & st_reg.mask[fsi_pkg::MSK_TWO]))
        && !ACCESS.wr) |=> !INT_N)
    else $error("unmasked event did not raise the interrupt");

  // An unmasked HDLC flag pulls the pin low in the next cycle.
  hdlc_irq_a: assert property (
    ((|(set_vec[fsi_pkg::LAT_HDLC_FLAG] & st_reg.mask[fsi_pkg::MSK_HDLC]))
        && !ACCESS.wr) |=> !INT_N)
    else $error("unmasked HDLC flag did not raise the interrupt");

  // With nothing pending, the pin is released in the next cycle.
  int_release_a: assert property (
    (pending_of(st_next) == 8'h00) |=> INT_N)
    else $error("interrupt held with nothing pending");

endmodule

// ### test/framer_status_interrupt_logic_tb_top.sv
`timescale 1ns/100ps
// Bench with a byte-wide model of the latched registers.
module framer_status_interrupt_logic_tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  fsi_pkg::fsi_src_type flags = '0;
  fsi_pkg::fsi_acc_type acc;
  logic [7:0] rdata;
  logic int_n;
  logic [7:0] d;
  int mismatches = 0;
  int checks = 0;
  int seed = 32'hd770d0c7;
  int lat[4];
  int cpy[4];

  fsi_top fsi_top_inst (.CLOCK(clock), .SYS_RST(sys_rst), .FLAG_IN(flags),
    .ACCESS(acc), .REG_RDATA(rdata), .INT_N(int_n));
  fsi_host fsi_host_inst (.clock(clock), .rdata(rdata), .acc(acc));

  // Free-running clock and a watchdog against hangs.
  initial forever #5 clock = ~clock;
  initial begin
    #60000;
    mismatches++;
    wrap_up();
  end

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // Interrupt level one edge later, once updates have landed.
  task automatic ichk(input logic e);
    @(posedge clock);
    #1 chk("int_n", {7'h00, e}, {7'h00, int_n});
  endtask
  // Level sources keep their latch bits set.
  task automatic relevel();
    for (int k = 0; k < 4; k++) lat[k] |= flags[k] & fsi_pkg::LEVEL_MASK[k];
  endtask
  // Poll one latched register and compare with the model.
  task automatic poll(input int i, input logic [7:0] m);
    repeat (4) @(posedge clock);
    relevel();
    cpy[i] = (cpy[i] & ~m) | (lat[i] & m);
    fsi_host_inst.scan(i[2:0], m, d);
    chk("latched", 8'(cpy[i]), d);
    lat[i] &= ~(d & m);
    relevel();
  endtask
  // One edge-type event pulse on a source bit.
  task automatic pulse(input int b, input int k);
    @(posedge clock);
    flags[b][k] <= 1'b1;
    lat[b] |= 1 << k;
    repeat (4) @(posedge clock);
    flags[b][k] <= 1'b0;
  endtask
  // Moves one source bit at an edge and waits until the flops carry it.
  task automatic drive(input int b, input int k, input logic v);
    @(posedge clock);
    flags[b][k] <= v;
    repeat (2) @(posedge clock);
  endtask
  task automatic wrap_up();
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    ichk(1'b1);
    fsi_host_inst.put(5, 8'hff);
    fsi_host_inst.put(6, 8'hff);
    fsi_host_inst.get(5, d);
    chk("mask_one", 8'hff, d);
    for (int k = 0; k < 8; k++) begin
      pulse(1, k);
      ichk(1'b0);
      poll(1, 8'h01 << k);
      ichk(1'b1);
      poll(1, 8'hff);
    end
    for (int k = 0; k < 8; k++) begin
      if (k == 3) continue;
      drive(0, k, 1'b1);
      if (k > 3) ichk(1'b0);
      poll(0, 8'h01 << k);
      if (k > 3) ichk(1'b1);
      poll(0, 8'h01 << k);
      drive(0, k, 1'b0);
      if (k > 3) ichk(1'b0);
      poll(0, 8'hff);
      ichk(1'b1);
    end
    fsi_host_inst.put(5, 8'h00);
    pulse(0, 3);
    ichk(1'b1);
    poll(0, 8'h08);
    flags[2] <= 8'($random(seed));
    poll(2, 8'hff);
    ichk(1'b1);
    flags[2] <= 8'h00;
    poll(2, 8'h0f);
    flags[4] <= 8'($random(seed));
    repeat (4) @(posedge clock);
    fsi_host_inst.get(4, d);
    chk("sync_state", flags[4], d);
    fsi_host_inst.put(4, ~flags[4]);
    fsi_host_inst.get(4, d);
    chk("sync_state", flags[4], d);
    fsi_host_inst.put(7, 8'hff);
    drive(3, 0, 1'b1);
    ichk(1'b0);
    relevel();
    drive(3, 0, 1'b0);
    poll(3, 8'hff);
    ichk(1'b1);
    wrap_up();
  end
endmodule

// ### test/fsi_host.sv
`timescale 1ns/100ps
// Host model on the control port; one access per put or get call, three per scan.
module fsi_host (
  input wire logic clock,
  input wire logic [7:0] rdata,
  output fsi_pkg::fsi_acc_type acc
);
  initial acc = '0;
  // Write one byte; the strobe stands through the taking edge.
  task automatic put(input logic [2:0] sel, input logic [7:0] d);
    @(posedge clock);
    acc <= '{wr: 1'b1, rd: 1'b0, sel: sel, wdata: d};
    @(posedge clock);
    acc <= '0;
  endtask
  // Read one byte; data settles just after the taking edge.
  task automatic get(input logic [2:0] sel, output logic [7:0] d);
    @(posedge clock);
    acc <= '{wr: 1'b0, rd: 1'b1, sel: sel, wdata: 8'h00};
    @(posedge clock);
    acc <= '0;
    #1 d = rdata;
  endtask
  // Mask write, read, then write back the read value under the mask.
  task automatic scan(input logic [2:0] sel, input logic [7:0] m,
                      output logic [7:0] d);
    put(sel, m);
    get(sel, d);
    put(sel, d & m);
  endtask
endmodule
